//--- design/tec_pkg.sv
// package of constants and types for the timer / external trigger counter
package tec_pkg;
  // ------------------------------------------------------------
  // widths and encodings
  // ------------------------------------------------------------
  localparam int TEC_CNT_W = 16;
  localparam logic [1:0] TEC_CK_DIV11 = 2'h0;
  localparam logic [1:0] TEC_CK_DIV7 = 2'h1;
  localparam logic [1:0] TEC_CK_DIV3 = 2'h2;
  localparam logic [1:0] TEC_CK_PIN = 2'h3;
  localparam logic [1:0] TEC_ST_STOP = 2'h0;
  localparam logic [1:0] TEC_ST_CMD = 2'h1;
  localparam logic [1:0] TEC_ST_RISE = 2'h2;
  localparam logic [1:0] TEC_ST_FALL = 2'h3;
  localparam logic [1:0] TEC_MODE_TIMER = 2'h0;
  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [15:0] TEC_CNT_RST = 16'h0000;
  localparam int TEC_DIV_W = 11;
  localparam int TEC_FS_DIV_W = 3;
  // filter times in high-frequency clock periods; one core cycle taken as 1/fc
  localparam int TEC_REJECT_FC = 4;
  localparam int TEC_DETECT_FC = 12;
  // a level must stand this many samples: more than reject, at most detect
  localparam int TEC_FILT_CYC = (TEC_REJECT_FC + TEC_DETECT_FC) / 2;

  typedef struct packed {
    logic auto_capture_enable;
    logic trigger_stop_select;
    logic [1:0] start_control_field;
    logic [1:0] source_clock_select;
    logic [1:0] operating_mode_select;
  } tec_ctrl_s;

  typedef enum logic [2:0] {
    TEC_IDLE = 3'b001,
    TEC_RUN = 3'b010,
    TEC_WAIT = 3'b100
  } tec_state_e;
endpackage

//--- design/tec_pin_filter.sv
// noise filter for the timer input pin
`timescale 1ns/10ps
module tec_pin_filter
  import tec_pkg::*;
#(
  parameter int FILT_CYC = TEC_FILT_CYC
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // pin side
  input wire logic i_pin,
  input wire logic i_bypass,
  // filtered level
  output logic o_level
);
  initial begin
    if (FILT_CYC < 2 || FILT_CYC > 255) begin
      $error("filter length out of range");
    end
  end

  logic [7:0] run;
  logic last;
  wire same = (i_pin == last);
  wire settle = same && (run == 8'(FILT_CYC - 1));

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      run <= 8'h00;
      last <= 1'b0;
      o_level <= 1'b0;
    end else begin
      last <= i_pin;
      run <= same ? ((run == 8'hff) ? run : run + 8'h01) : 8'h00;
      // low-speed modes skip the filter; the source holds a machine cycle
      if (i_bypass) begin
        o_level <= i_pin;
      end else if (settle) begin
        o_level <= last;
      end
    end
  end

  // with i_bypass low, short glitches never reach the output
  filt_reject_a: assert property (@(posedge i_clock) disable iff (i_rst)
    (!i_bypass && !$past(i_bypass) && $changed(o_level)) |-> $past(same))
    else $error("filtered level changed on an unsettled input");
endmodule

//--- design/tec_timer.sv
// 16-bit up-counter: timer mode and external trigger timer mode
// ------------------------------------------------------------
// Overview of operation
// - unit has six modes; this block does timer and external trigger timer
// - timer mode counts each source tick and restarts after every clear
// - timer mode match with compare A raises interrupt and clears counter
// - with auto capture on, counter copies into capture B each tick
// - trigger mode idles until trigger edge, then counts source ticks
// - trigger edge is rising or falling per start control field
// - stop select 1: match clears, halts counter and raises interrupt
// - stop select 1: opposite edge before match clears and halts, no interrupt
// - halted counter restarts on the next selected trigger edge
// - stop select 0: match clears, halts, interrupts; opposite edges ignored
// - stop select 0: trigger edge while counting is ignored
// - pin filter rejects 4/fc pulses, detects 12/fc pulses
// - low speed and sleep bypass the filter; source holds a machine cycle; here only i_low_speed drives the filter bypass
// - clock select 00 fc/2^11 or fs/2^3, 01 fc/2^7, 10 fc/2^3, 11 pin
// - start field 00 stop and clear, 01 command, 10 rise, 11 fall
// - compare A loads low then high; takes effect on next tick after high
// - mode 00 selects timer group; trigger mode chosen by edge start codes
// ------------------------------------------------------------
`timescale 1ns/10ps
module tec_timer
  import tec_pkg::*;
#(
  parameter int CNT_W = TEC_CNT_W
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // control register fields
  input wire tec_ctrl_s i_ctrl,
  input wire logic i_prescaler_tap_select,
  input wire logic i_low_speed,
  input wire logic i_low_freq_tick,
  // compare register byte writes
  input wire logic i_cmp_lo_we,
  input wire logic i_cmp_hi_we,
  input wire logic [7:0] i_cmp_byte,
  // timer input pin
  input wire logic i_timer_input_pin,
  // state out
  output logic [CNT_W-1:0] o_counter,
  output logic [CNT_W-1:0] o_compare_reg_a,
  output logic [CNT_W-1:0] o_capture_reg_b,
  output logic o_running,
  output logic o_timer_match_irq
);
  initial begin
    if (CNT_W != 16) begin
      $error("compare register byte loading serves 16 bits only");
    end
  end

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_s1;
  logic rst_s2;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst = !rst_s2;

  // ------------------------------------------------------------
  // prescaler and source tick
  // ------------------------------------------------------------
  logic [TEC_DIV_W-1:0] presc;
  always_ff @(posedge i_clock or posedge rst) begin
    if (rst) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end
  wire tick_d11 = (presc == {TEC_DIV_W{1'b1}});
  wire tick_d7 = (presc[6:0] == 7'h7f);
  wire tick_d3 = (presc[2:0] == 3'h7);

  // fs/2^3 from low-frequency ticks
  logic [TEC_FS_DIV_W-1:0] fs_div;
  always_ff @(posedge i_clock or posedge rst) begin
    if (rst) begin
      fs_div <= '0;
    end else if (i_low_freq_tick) begin
      fs_div <= fs_div + 1'b1;
    end
  end
  wire tick_fs3 = i_low_freq_tick && (fs_div == {TEC_FS_DIV_W{1'b1}});
  wire use_fs = i_prescaler_tap_select || i_low_speed;

  // ------------------------------------------------------------
  // pin filter and edges
  // ------------------------------------------------------------
  logic pin_level;
  logic pin_prev;
  tec_pin_filter #(
    .FILT_CYC(TEC_FILT_CYC)
  ) u_filter (
    .i_clock(i_clock),
    .i_rst(rst),
    .i_pin(i_timer_input_pin),
    .i_bypass(i_low_speed),
    .o_level(pin_level)
  );
  always_ff @(posedge i_clock or posedge rst) begin
    if (rst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_level;
    end
  end
  wire rise = pin_level && !pin_prev;
  wire fall = !pin_level && pin_prev;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire [1:0] sel = i_ctrl.source_clock_select;
  wire [1:0] stc = i_ctrl.start_control_field;
  wire src_tick = (sel == TEC_CK_DIV11) ? (use_fs ? tick_fs3 : tick_d11) :
                  (sel == TEC_CK_DIV7) ? tick_d7 :
                  (sel == TEC_CK_DIV3) ? tick_d3 : rise;
  // only the timer group of the unit is served here; other modes clear and stop the counter
  wire mode_ok = (i_ctrl.operating_mode_select == TEC_MODE_TIMER);
  wire trig_mode = mode_ok && ((stc == TEC_ST_RISE) || (stc == TEC_ST_FALL));
  wire timer_mode = mode_ok && (stc == TEC_ST_CMD);
  wire stopped = (stc == TEC_ST_STOP) || !mode_ok;
  wire trig_edge = (stc == TEC_ST_RISE) ? rise : fall;
  wire opp_edge = (stc == TEC_ST_RISE) ? fall : rise;
  wire match = (o_counter == o_compare_reg_a);

  // ------------------------------------------------------------
  // compare register A: two-stage byte load
  // ------------------------------------------------------------
  logic [7:0] cmp_lo;
  logic [CNT_W-1:0] cmp_pend;
  logic cmp_new;
  always_ff @(posedge i_clock or posedge rst) begin
    if (rst) begin
      cmp_lo <= 8'h00;
      cmp_pend <= TEC_CNT_RST;
      cmp_new <= 1'b0;
      o_compare_reg_a <= TEC_CNT_RST;
    end else begin
      if (i_cmp_lo_we) begin
        cmp_lo <= i_cmp_byte;
      end
      // a high write arriving with a tick still wins the pending flag
      if (i_cmp_hi_we) begin
        cmp_pend <= {i_cmp_byte, cmp_lo};
        cmp_new <= 1'b1;
      end else if (src_tick && cmp_new) begin
        o_compare_reg_a <= cmp_pend;
        cmp_new <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // counter state machine
  // ------------------------------------------------------------
  tec_state_e state;
  tec_state_e next_state;
  always_comb begin
    next_state = state;
    case (state)
      TEC_IDLE: begin
        if (timer_mode) begin
          next_state = TEC_RUN;
        end else if (trig_mode) begin
          next_state = TEC_WAIT;
        end
      end
      TEC_WAIT: begin
        if (stopped) begin
          next_state = TEC_IDLE;
        end else if (trig_edge) begin
          next_state = TEC_RUN;
        end
      end
      TEC_RUN: begin
        if (stopped) begin
          next_state = TEC_IDLE;
        end else if (trig_mode && src_tick && match) begin
          next_state = TEC_WAIT;
        end else if (trig_mode && i_ctrl.trigger_stop_select && opp_edge) begin
          next_state = TEC_WAIT;
        end
      end
      default: begin
        next_state = TEC_IDLE;
      end
    endcase
  end

  // opposite edge halts only with stop select set; a repeat trigger is not looked at
  wire halt_opp = (state == TEC_RUN) && trig_mode && i_ctrl.trigger_stop_select
                  && opp_edge;
  wire run_tick = (state == TEC_RUN) && src_tick && !stopped;
  wire hit = run_tick && match && (timer_mode || trig_mode);

  always_ff @(posedge i_clock or posedge rst) begin
    if (rst) begin
      state <= TEC_IDLE;
      o_counter <= TEC_CNT_RST;
      o_capture_reg_b <= TEC_CNT_RST;
      o_timer_match_irq <= 1'b0;
    end else begin
      state <= next_state;
      o_timer_match_irq <= hit;
      if (stopped || halt_opp || hit) begin
        o_counter <= TEC_CNT_RST;
      end else if (run_tick) begin
        o_counter <= o_counter + 1'b1;
      end
      if (run_tick && i_ctrl.auto_capture_enable) begin
        o_capture_reg_b <= o_counter;
      end
    end
  end
  assign o_running = (state == TEC_RUN);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  match_irq_a: assert property (@(posedge i_clock) disable iff (rst)
    hit |=> (o_timer_match_irq && o_counter == TEC_CNT_RST))
    else $error("match did not interrupt and clear");
  irq_pulse_a: assert property (@(posedge i_clock) disable iff (rst)
    o_timer_match_irq |=> !o_timer_match_irq)
    else $error("match interrupt longer than one cycle");
  count_up_a: assert property (@(posedge i_clock) disable iff (rst)
    (run_tick && !hit && !halt_opp) |=> (o_counter == $past(o_counter) + 16'h0001))
    else $error("counter missed a source tick");
  capture_a: assert property (@(posedge i_clock) disable iff (rst)
    (run_tick && i_ctrl.auto_capture_enable) |=> (o_capture_reg_b == $past(o_counter)))
    else $error("capture register not updated");
  idle_wait_a: assert property (@(posedge i_clock) disable iff (rst)
    (state == TEC_WAIT && !trig_edge) |=> (o_counter == TEC_CNT_RST))
    else $error("counter moved before trigger");
  trig_start_a: assert property (@(posedge i_clock) disable iff (rst)
    (state == TEC_WAIT && trig_edge && !stopped) |=> o_running)
    else $error("trigger edge did not start counter");
  opp_halt_a: assert property (@(posedge i_clock) disable iff (rst)
    (halt_opp && !hit) |=> (!o_running && !o_timer_match_irq && o_counter == TEC_CNT_RST))
    else $error("opposite edge did not halt quietly");
  opp_ignore_a: assert property (@(posedge i_clock) disable iff (rst)
    (o_running && trig_mode && !i_ctrl.trigger_stop_select && !stopped && !hit)
      |=> o_running)
    else $error("counting stopped without match");
  stop_clear_a: assert property (@(posedge i_clock) disable iff (rst)
    (stc == TEC_ST_STOP) |=> (o_counter == TEC_CNT_RST && !o_running))
    else $error("stop code did not clear counter");
  cmp_load_a: assert property (@(posedge i_clock) disable iff (rst)
    (cmp_new && src_tick && !i_cmp_hi_we) |=> (o_compare_reg_a == $past(cmp_pend)))
    else $error("compare value not loaded on tick");
endmodule

//--- testbench/tec_pulse_src.sv
// external pulse source that drives the timer input pin
`timescale 1ns/10ps
module tec_pulse_src (
  // bench control
  input wire logic i_clock,
  input wire logic i_go,
  input wire logic [7:0] i_width,
  input wire logic i_idle,
  // pin
  output logic o_pin
);
  logic [7:0] left = 8'h00;

  // the pin rests at the idle level and each pulse is held whole
  assign o_pin = (left != 8'h00) ? ~i_idle : i_idle;

  always @(posedge i_clock) begin
    if (i_go) begin
      left <= i_width;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
endmodule

//--- testbench/tec_timer_tb_top.sv
// self-checking bench for the timer / external trigger counter
`timescale 1ns/10ps
module tec_timer_tb_top
  import tec_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  tec_ctrl_s ctrl = '0;
  logic [1:0] ck = TEC_CK_DIV3;
  logic lo_we = 1'b0;
  logic hi_we = 1'b0;
  logic low_speed = 1'b0;
  logic tap = 1'b0;
  logic lf_tick = 1'b0;
  logic capok;
  logic go = 1'b0;
  logic idle = 1'b0;
  logic [7:0] cbyte = 8'h00;
  logic [7:0] width = 8'h00;
  logic pin, run, irq, prev_irq;
  logic [15:0] cnt, cmpa, capb, prev, a;
  logic [31:0] seed = 32'hae1f_c7b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int irqs = 0;
  int n0;

  always #4 i_clock = ~i_clock;

  // low-frequency tick every second cycle, so the fs/2^3 source ticks every 16 cycles
  always @(negedge i_clock) lf_tick = !lf_tick;

  tec_pulse_src src_u (.i_clock(i_clock), .i_go(go), .i_width(width), .i_idle(idle),
    .o_pin(pin));
  tec_timer dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ctrl(ctrl),
    .i_prescaler_tap_select(tap), .i_low_speed(low_speed), .i_low_freq_tick(lf_tick),
    .i_cmp_lo_we(lo_we), .i_cmp_hi_we(hi_we), .i_cmp_byte(cbyte),
    .i_timer_input_pin(pin), .o_counter(cnt), .o_compare_reg_a(cmpa),
    .o_capture_reg_b(capb), .o_running(run), .o_timer_match_irq(irq));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic set_a(input logic [15:0] v);
    lo_we = 1'b1;
    cbyte = v[7:0];
    cyc(1);
    lo_we = 1'b0;
    hi_we = 1'b1;
    cbyte = v[15:8];
    cyc(1);
    hi_we = 1'b0;
    for (int i = 0; i < 40 && cmpa !== v; i++) cyc(1);
    chk("compare_a", v, cmpa);
  endtask

  // control only changes while stopped, so stop first
  task automatic ctl(input logic cap, input logic stp, input logic [1:0] st,
    input logic [1:0] md);
    ctrl.start_control_field = TEC_ST_STOP;
    cyc(1);
    ctrl = '{cap, stp, TEC_ST_STOP, ck, md};
    cyc(1);
    ctrl.start_control_field = st;
    cyc(1);
  endtask

  task automatic pulse(input logic [7:0] w);
    go = 1'b1;
    width = w;
    cyc(1);
    go = 1'b0;
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----
  // match monitor
  // ----
  always @(negedge i_clock) begin
    if (i_rst_n && irq) begin
      irqs++;
      chk("count_at_match", cmpa, prev);
      chk("count_after_match", 16'h0000, cnt);
      chk("irq_width", 16'h0000, 16'(prev_irq));
    end
    if (i_rst_n && run && cnt > cmpa) chk("count_bound", cmpa, cnt);
    prev = cnt;
    prev_irq = irq;
  end

  // ----
  // scenarios
  // ----
  initial begin
    ctrl.source_clock_select = TEC_CK_DIV3;
    cyc(20);
    i_rst_n = 1'b1;
    cyc(4);
    chk("counter", 16'h0000, cnt);
    chk("capture_b", 16'h0000, capb);
    lo_we = 1'b1;
    cbyte = 8'h55;
    cyc(1);
    lo_we = 1'b0;
    cyc(40);
    chk("compare_a", 16'h0000, cmpa);
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      a = 16'h0002 + {13'h0000, seed[2:0]};
      set_a(a);
      n0 = irqs;
      ck = (k == 3) ? TEC_CK_DIV7 : (k == 2) ? TEC_CK_DIV11 : TEC_CK_DIV3;
      tap = (k == 2);
      ctl(k[0], 1'b0, TEC_ST_CMD, TEC_MODE_TIMER);
      cyc(3 * (a + 1) * ((k == 3) ? 128 : (k == 2) ? 16 : 8));
      chk("irq_count", 16'h0001, 16'((irqs - n0) inside {[2:3]}));
      capok = (capb == cnt) || (capb + 1 == cnt) || (cnt == 0);
      if (k[0]) chk("capture_b", 16'h0001, 16'(capok));
      ck = TEC_CK_DIV3;
      ctl(1'b0, 1'b0, TEC_ST_STOP, TEC_MODE_TIMER);
      chk("counter", 16'h0000, cnt);
    end
    for (int e = 0; e < 2; e++) begin
      idle = e[0];
      set_a(16'h0100);
      n0 = irqs;
      ctl(1'b0, 1'b1, e[0] ? TEC_ST_FALL : TEC_ST_RISE, TEC_MODE_TIMER);
      cyc(40);
      chk("running", 16'h0000, 16'(run));
      pulse(8'h04);
      cyc(30);
      chk("running", 16'h0000, 16'(run));
      pulse(8'h64);
      cyc(60);
      chk("running", 16'h0001, 16'(run));
      chk("counting", 16'h0001, 16'(cnt != 0));
      cyc(60);
      chk("running", 16'h0000, 16'(run));
      chk("counter", 16'h0000, cnt);
      chk("irq_count", 16'h0000, 16'(irqs - n0));
      pulse(8'h0c);
      cyc(15);
      chk("running", 16'h0001, 16'(run));
      cyc(30);
      set_a(16'h0003);
      pulse(8'hc8);
      cyc(230);
      chk("irq_count", 16'h0001, 16'(irqs - n0));
      chk("running", 16'h0000, 16'(run));
    end
    idle = 1'b0;
    set_a(16'h0014);
    n0 = irqs;
    ctl(1'b0, 1'b0, TEC_ST_RISE, TEC_MODE_TIMER);
    pulse(8'h1e);
    cyc(60);
    chk("running", 16'h0001, 16'(run));
    pulse(8'h1e);
    cyc(140);
    chk("irq_count", 16'h0001, 16'(irqs - n0));
    chk("running", 16'h0000, 16'(run));
    ctl(1'b0, 1'b0, TEC_ST_CMD, 2'h1);
    cyc(100);
    chk("counter", 16'h0000, cnt);
    chk("running", 16'h0000, 16'(run));
    // pin as source clock: three filtered rising edges reach a compare value of 2
    set_a(16'h0002);
    n0 = irqs;
    ck = TEC_CK_PIN;
    ctl(1'b0, 1'b0, TEC_ST_CMD, TEC_MODE_TIMER);
    repeat (3) begin
      pulse(8'h14);
      cyc(40);
    end
    chk("irq_count", 16'h0001, 16'(irqs - n0));
    chk("counter", 16'h0000, cnt);
    ck = TEC_CK_DIV3;
    low_speed = 1'b1;
    ctl(1'b0, 1'b0, TEC_ST_RISE, TEC_MODE_TIMER);
    pulse(8'h03);
    cyc(10);
    chk("running", 16'h0001, 16'(run));
    ctl(1'b0, 1'b0, TEC_ST_STOP, TEC_MODE_TIMER);
    low_speed = 1'b0;
    summarize();
  end

  // the whole run needs under half of this span; a hang ends here
  initial begin
    repeat (20000) @(posedge i_clock);
    error_cnt++;
    $display("Error watchdog expected done seen hang");
    summarize();
  end
endmodule
